// [logic/dp_ram_pkg.sv]
// Purpose: Shared constants and types for the dual-port block memory.
// Assumes: Registers are 32-bit words on APB at byte offsets.
// Notes:   Memory words are four 9-bit lanes.
`default_nettype none
package dp_ram_pkg;

    localparam int MEM_ADDR_W = 8;
    localparam int MEM_DATA_W = 36;
    localparam int MEM_DEPTH  = 256;
    localparam int LANE_W     = 9;
    localparam int LANES      = 4;

    localparam logic [17:0] SHIFT_MAX_BITS = 18'h01200;

    localparam logic [11:0] OFS_CONFIG = 12'h000;
    localparam logic [11:0] OFS_SHIFT  = 12'h004;
    localparam logic [11:0] OFS_STATUS = 12'h008;

    localparam int CFG_MODE_LSB   = 0;
    localparam int CFG_SIMPLE_BIT = 2;
    localparam int CFG_INSEL_BIT  = 3;
    localparam int CFG_OUTSEL_BIT = 4;
    localparam int CFG_BYPA_BIT   = 5;
    localparam int CFG_BYPB_BIT   = 6;
    localparam int CFG_WIDTH_LSB  = 7;
    localparam int CFG_SHEN_BIT   = 10;
    localparam logic [31:0] CFG_MASK  = 32'h000007FF;
    localparam logic [31:0] CFG_RESET = 32'h00000200;

    localparam int SH_DEPTH_LSB = 0;
    localparam int SH_WIDTH_LSB = 9;
    localparam int SH_TAPS_LSB  = 15;
    localparam logic [31:0] SH_MASK  = 32'h0003FFFF;
    localparam logic [31:0] SH_RESET = 32'h00009210;

    localparam int ST_ERR_BIT    = 0;
    localparam int ST_ACTIVE_BIT = 1;
    localparam int ST_COUNT_LSB  = 16;

    typedef enum logic [1:0] {
        CM_IND = 2'b00,
        CM_IO  = 2'b01,
        CM_RW  = 2'b10,
        CM_RSV = 2'b11
    } clk_mode_t;

    typedef enum logic [2:0] {
        WD_9  = 3'b000,
        WD_16 = 3'b001,
        WD_18 = 3'b010,
        WD_32 = 3'b011,
        WD_36 = 3'b100
    } width_t;

endpackage
`default_nettype wire

// [logic/dp_ram_store.sv]
// Purpose: Two-port word store with bit write enables.
// Assumes: Both ports run on one clock.
// Notes:   Reads return the old word; port A wins a same-address write.
`timescale 1ns/1ps
`default_nettype none
module dp_ram_store #(
    parameter int AW = 8,
    parameter int DW = 36
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic          we_a,
    input  wire logic          re_a,
    input  wire logic [AW-1:0] addr_a,
    input  wire logic [DW-1:0] be_a,
    input  wire logic [DW-1:0] wd_a,
    output logic      [DW-1:0] q_a,
    input  wire logic          we_b,
    input  wire logic          re_b,
    input  wire logic [AW-1:0] addr_b,
    input  wire logic [DW-1:0] be_b,
    input  wire logic [DW-1:0] wd_b,
    output logic      [DW-1:0] q_b
);

    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk) begin
        for (int i = 0; i < DW; i++) begin
            if (we_b && be_b[i]) begin
                mem[addr_b][i] <= wd_b[i];
            end
            if (we_a && be_a[i]) begin
                mem[addr_a][i] <= wd_a[i];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q_a <= '0;
            q_b <= '0;
        end else begin
            if (re_a) begin
                q_a <= mem[addr_a];
            end
            if (re_b) begin
                q_b <= mem[addr_b];
            end
        end
    end

endmodule
`default_nettype wire

// [logic/dp_ram_core.sv]
// Purpose: Dual-port block memory with three clocking schemes and APB setup.
// Assumes: Port ticks, enables and clears come from logic on pclk.
// Notes:   In simple dual-port use port A writes and port B reads.
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Shift mode limited to 4608 bits
// - Byte masking only in 16/18/32/36 widths
// - Unmasked lanes keep stored contents
// - Mask bit k gates 9-bit lane k
// - In 32/36 widths any mask pattern writes exactly those lanes; 16/18 widths use mask bits 1:0 only
// - Eight-bit lanes in 16/32 widths
// - Input and output clocks selectable
// - Inputs always registered, output bypassable
// - Independent mode: each port own clock
// - Independent mode: per-port enable and clear
// - In/out mode: one clock captures inputs
// - In/out mode: second clock drives outputs
// - Simple dual-port read enable ignores clear
// - Read/write mode: write clock captures writes
// - Read/write mode: read clock handles reads
// - Read/write mode: own enables and clears
module dp_ram_core
    import dp_ram_pkg::*;
#(
    parameter int ADDR_W = MEM_ADDR_W,
    parameter int DATA_W = MEM_DATA_W
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic [11:0]       paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              tick_a,
    input  wire logic              tick_b,
    input  wire logic              ce_a,
    input  wire logic              ce_b,
    input  wire logic              clr_a,
    input  wire logic              clr_b,
    input  wire logic              we_a,
    input  wire logic              re_a,
    input  wire logic [ADDR_W-1:0] addr_a,
    input  wire logic [3:0]        mask_a,
    input  wire logic [DATA_W-1:0] wdata_a,
    output logic      [DATA_W-1:0] rdata_a,
    input  wire logic              we_b,
    input  wire logic              re_b,
    input  wire logic [ADDR_W-1:0] addr_b,
    input  wire logic [3:0]        mask_b,
    input  wire logic [DATA_W-1:0] wdata_b,
    output logic      [DATA_W-1:0] rdata_b,
    input  wire logic [DATA_W-1:0] shift_in,
    output logic      [DATA_W-1:0] shift_out
);

    if (DATA_W != MEM_DATA_W || ADDR_W < 1 || ADDR_W > MEM_ADDR_W) begin
        $error("dp_ram_core: unsupported width or depth");
    end

    function automatic logic [3:0] lane_en(width_t w, logic [3:0] m);
        unique case (w)
            WD_16, WD_18: lane_en = {2'b00, m[1:0]};
            WD_32, WD_36: lane_en = m;
            default:      lane_en = 4'h1;
        endcase
    endfunction

    function automatic logic [35:0] bit_en(logic [3:0] l);
        bit_en = '0;
        for (int k = 0; k < LANES; k++) begin
            bit_en[k*LANE_W +: LANE_W] = {LANE_W{l[k]}};
        end
    endfunction

    function automatic logic is_byte_mode(width_t w);
        is_byte_mode = (w == WD_16) || (w == WD_32);
    endfunction

    function automatic logic [35:0] pack_in(width_t w, logic [35:0] d);
        pack_in = d;
        if (is_byte_mode(w)) begin
            pack_in = '0;
            for (int k = 0; k < LANES; k++) begin
                pack_in[k*LANE_W +: 8] = d[k*8 +: 8];
            end
        end
    endfunction

    function automatic logic [35:0] unpack_out(width_t w, logic [35:0] q);
        unpack_out = q;
        if (is_byte_mode(w)) begin
            unpack_out = '0;
            for (int k = 0; k < LANES; k++) begin
                unpack_out[k*8 +: 8] = q[k*LANE_W +: 8];
            end
        end
    endfunction

    logic [31:0] cfg;
    logic [31:0] shift_cfg;
    logic [15:0] write_count;

    clk_mode_t   cfg_mode;
    width_t      cfg_width;
    logic        simple_dp;
    logic [8:0]  sh_depth;
    logic [5:0]  sh_width;
    logic [2:0]  sh_taps;
    logic [17:0] shift_bits;
    logic [11:0] shift_len;
    logic        cfg_err;
    logic        shift_on;
    logic        apb_go;
    logic        addr_ok;

    assign cfg_mode   = clk_mode_t'(cfg[CFG_MODE_LSB +: 2]);
    assign cfg_width  = width_t'(cfg[CFG_WIDTH_LSB +: 3]);
    assign simple_dp  = (cfg_mode == CM_RW) ||
                        (cfg_mode == CM_IO && cfg[CFG_SIMPLE_BIT]);
    assign sh_depth   = shift_cfg[SH_DEPTH_LSB +: 9];
    assign sh_width   = shift_cfg[SH_WIDTH_LSB +: 6];
    assign sh_taps    = shift_cfg[SH_TAPS_LSB +: 3];
    assign shift_bits = 18'(sh_depth) * 18'(sh_taps) * 18'(sh_width);
    assign shift_len  = 12'(sh_depth) * 12'(sh_taps);
    assign cfg_err    = (shift_bits > SHIFT_MAX_BITS) ||
                        (shift_len > 12'(MEM_DEPTH)) ||
                        (shift_len == 12'h000) ||
                        (sh_width > 6'(MEM_DATA_W));
    assign shift_on   = cfg[CFG_SHEN_BIT] && !cfg_err;
    assign apb_go     = psel && penable && pready;
    assign addr_ok    = (paddr == OFS_CONFIG) || (paddr == OFS_SHIFT) ||
                        (paddr == OFS_STATUS);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= '0;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            pslverr <= !addr_ok;
            unique case (paddr)
                OFS_CONFIG: prdata <= cfg;
                OFS_SHIFT:  prdata <= shift_cfg;
                OFS_STATUS: prdata <= {write_count, 14'h0000,
                                       shift_on, cfg_err};
                default:    prdata <= '0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg       <= CFG_RESET;
            shift_cfg <= SH_RESET;
        end else if (apb_go && pwrite) begin
            if (paddr == OFS_CONFIG) begin
                cfg <= pwdata & CFG_MASK;
            end
            if (paddr == OFS_SHIFT) begin
                shift_cfg <= pwdata & SH_MASK;
            end
        end
    end

    logic [1:0] in_cap;
    logic [1:0] in_clr;
    logic [1:0] out_cap;
    logic [1:0] out_clr;
    logic [1:0] can_wr;
    logic [1:0] can_rd;
    logic       tick_in;
    logic       tick_out;

    assign tick_in  = cfg[CFG_INSEL_BIT] ? tick_b : tick_a;
    assign tick_out = cfg[CFG_OUTSEL_BIT] ? tick_b : tick_a;

    always_comb begin
        in_cap  = '0;
        in_clr  = '0;
        out_cap = '0;
        out_clr = '0;
        unique case (cfg_mode)
            CM_IO: begin
                in_cap  = {2{tick_in && ce_a}};
                in_clr  = {2{clr_a}};
                out_cap = {2{tick_out && ce_b}};
                out_clr = {2{clr_b}};
            end
            CM_RW: begin
                in_cap  = {tick_b && ce_b, tick_a && ce_a};
                in_clr  = {clr_b, clr_a};
                out_cap = {tick_b && ce_b, 1'b0};
                out_clr = {clr_b, clr_a};
            end
            default: begin
                in_cap  = {tick_b && ce_b, tick_a && ce_a};
                in_clr  = {clr_b, clr_a};
                out_cap = {tick_b && ce_b, tick_a && ce_a};
                out_clr = {clr_b, clr_a};
            end
        endcase
        if (shift_on) begin
            in_cap  = '0;
            out_cap = '0;
        end
    end

    assign can_wr = simple_dp ? 2'b01 : 2'b11;
    assign can_rd = simple_dp ? 2'b10 : 2'b11;

    logic [1:0]              we_q;
    logic [1:0]              re_q;
    logic [1:0]              fire;
    logic [ADDR_W-1:0]       addr_q [2];
    logic [3:0]              mask_q [2];
    logic [DATA_W-1:0]       wd_q [2];
    logic [1:0]              we_in;
    logic [1:0]              re_in;
    logic [ADDR_W-1:0]       addr_in [2];
    logic [3:0]              mask_in [2];
    logic [DATA_W-1:0]       wd_in [2];

    assign we_in      = {we_b, we_a};
    assign re_in      = {re_b, re_a};
    assign addr_in[0] = addr_a;
    assign addr_in[1] = addr_b;
    assign mask_in[0] = mask_a;
    assign mask_in[1] = mask_b;
    assign wd_in[0]   = wdata_a;
    assign wd_in[1]   = wdata_b;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            we_q <= '0;
            fire <= '0;
            for (int p = 0; p < 2; p++) begin
                addr_q[p] <= '0;
                mask_q[p] <= '0;
                wd_q[p]   <= '0;
            end
        end else begin
            for (int p = 0; p < 2; p++) begin
                fire[p] <= in_cap[p] && !in_clr[p];
                if (in_clr[p]) begin
                    we_q[p]   <= 1'b0;
                    addr_q[p] <= '0;
                    mask_q[p] <= '0;
                    wd_q[p]   <= '0;
                end else if (in_cap[p]) begin
                    we_q[p]   <= we_in[p];
                    addr_q[p] <= addr_in[p];
                    mask_q[p] <= mask_in[p];
                    wd_q[p]   <= wd_in[p];
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            re_q <= '0;
        end else begin
            for (int p = 0; p < 2; p++) begin
                if (in_clr[p] && !simple_dp) begin
                    re_q[p] <= 1'b0;
                end else if (in_cap[p]) begin
                    re_q[p] <= re_in[p];
                end
            end
        end
    end

    logic [7:0]        ptr;
    logic              shift_step;
    logic              shift_fire;
    logic [36:0]       sh_ones;
    logic [1:0]        mem_we;
    logic [1:0]        mem_re;
    logic [ADDR_W-1:0] mem_addr [2];
    logic [35:0]       mem_be [2];
    logic [35:0]       mem_wd [2];
    logic [35:0]       mem_q [2];

    assign shift_step = shift_on && tick_a && ce_a && !clr_a;
    assign sh_ones    = (37'h0000000001 << sh_width) - 37'h0000000001;

    always_comb begin
        for (int p = 0; p < 2; p++) begin
            mem_we[p]   = fire[p] && we_q[p] && can_wr[p];
            mem_re[p]   = fire[p] && re_q[p] && can_rd[p];
            mem_addr[p] = addr_q[p];
            mem_be[p]   = bit_en(lane_en(cfg_width, mask_q[p]));
            mem_wd[p]   = pack_in(cfg_width, wd_q[p]);
        end
        if (shift_on) begin
            mem_we      = {1'b0, shift_step};
            mem_re      = {shift_step, 1'b0};
            mem_addr[0] = ADDR_W'(ptr);
            mem_addr[1] = ADDR_W'(ptr);
            mem_be[0]   = '1;
            mem_wd[0]   = shift_in & sh_ones[35:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr        <= '0;
            shift_fire <= 1'b0;
        end else begin
            shift_fire <= shift_step;
            if (!shift_on) begin
                ptr <= '0;
            end else if (shift_step) begin
                ptr <= (12'(ptr) >= shift_len - 12'h001) ? 8'h00 : ptr + 8'h01;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            write_count <= '0;
        end else begin
            write_count <= write_count + 16'(mem_we[0]) + 16'(mem_we[1]);
        end
    end

    dp_ram_store #(
        .AW (ADDR_W),
        .DW (DATA_W)
    ) u_store (
        .clk    (pclk),
        .rst_n  (presetn),
        .we_a   (mem_we[0]),
        .re_a   (mem_re[0]),
        .addr_a (mem_addr[0]),
        .be_a   (mem_be[0]),
        .wd_a   (mem_wd[0]),
        .q_a    (mem_q[0]),
        .we_b   (mem_we[1]),
        .re_b   (mem_re[1]),
        .addr_b (mem_addr[1]),
        .be_b   (mem_be[1]),
        .wd_b   (mem_wd[1]),
        .q_b    (mem_q[1])
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_a <= '0;
        end else if (out_clr[0]) begin
            rdata_a <= '0;
        end else if (cfg[CFG_BYPA_BIT] || out_cap[0]) begin
            rdata_a <= unpack_out(cfg_width, mem_q[0]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_b <= '0;
        end else if (out_clr[1]) begin
            rdata_b <= '0;
        end else if (cfg[CFG_BYPB_BIT] || out_cap[1]) begin
            rdata_b <= unpack_out(cfg_width, mem_q[1]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_out <= '0;
        end else if (clr_b) begin
            shift_out <= '0;
        end else if (shift_fire) begin
            shift_out <= mem_q[1];
        end
    end

endmodule
`default_nettype wire

// [bench/dp_ram_core_checker.sv]
// Purpose: Port-level assertions for the dual-port block memory.
// Assumes: One clock domain, pclk, with presetn as its reset.
// Notes:   Bound to the core from the testbench top file.
`timescale 1ns/1ps
`default_nettype none
module dp_ram_core_checker
    import dp_ram_pkg::*;
#(
    parameter int ADDR_W = MEM_ADDR_W,
    parameter int DATA_W = MEM_DATA_W
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic [11:0]       paddr,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              tick_a,
    input wire logic              tick_b,
    input wire logic              clr_a,
    input wire logic              clr_b,
    input wire logic [DATA_W-1:0] rdata_a,
    input wire logic [DATA_W-1:0] rdata_b,
    input wire logic [DATA_W-1:0] shift_out
);
    logic mapped;
    assign mapped = (paddr == OFS_CONFIG) || (paddr == OFS_SHIFT)
                    || (paddr == OFS_STATUS);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable;
    endsequence
    a_wait_state: assert property (setup_s ##1 access_s |-> !pready ##1 pready)
        else $error("pready not after exactly one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_ready_access: assert property (pready |-> access_s)
        else $error("pready outside an access phase");
    a_err_decode: assert property (pready |-> (pslverr == !mapped))
        else $error("pslverr does not match the address decode");
    a_err_zero_read: assert property (pready && pslverr && !pwrite
                                      |-> prdata == 32'h00000000)
        else $error("refused read returned nonzero data");
    a_clear_outputs: assert property (
        clr_a && clr_b |=> rdata_a == '0 && rdata_b == '0)
        else $error("read data not cleared");
    a_rdata_hold: assert property (
        (!tick_a && !tick_b && !clr_a && !clr_b && !psel) [*3]
        |=> $stable(rdata_a) && $stable(rdata_b))
        else $error("read data moved without a port strobe");
    a_shift_hold: assert property (
        (!tick_a && !clr_a && !clr_b && !psel) [*3] |=> $stable(shift_out))
        else $error("shift output moved without a step");
endmodule
`default_nettype wire

// [bench/fabric_user_model.sv]
// Purpose: Fabric user logic that makes the port strobes.
// Assumes: Strobes are levels launched from pclk logic.
// Notes:   Shared mode feeds one strobe to both ports.
`timescale 1ns/1ps
`default_nettype none
module fabric_user_model (
    input  wire logic presetn,
    input  wire logic run_a,
    input  wire logic run_b,
    input  wire logic share,
    output logic      tick_a,
    output logic      tick_b
);
    // Two clocks at most.
    // Only two strobe sources exist, one of which may feed both ports.
    assign tick_a = run_a & presetn;
    assign tick_b = (share ? run_a : run_b) & presetn;
endmodule
`default_nettype wire

// [bench/tb_top.sv]
// Purpose: Self-checking bench for the dual-port block memory.
// Assumes: Port strobes come from the fabric user model.
// Notes:   Reads wait five cycles so every read latency has drained.
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import dp_ram_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, prd;
    logic        perr, run_a, run_b, share, tick_a, tick_b;
    logic        ce_a, ce_b, clr_a, clr_b, we_a, re_a, we_b, re_b;
    logic [7:0]  addr_a, addr_b;
    logic [3:0]  mask_a, mask_b;
    logic [35:0] wdata_a, wdata_b, rdata_a, rdata_b, shift_in, shift_out;
    logic [35:0] exp, wd;
    int          err_total, comparisons;

    dp_ram_core #(.ADDR_W(8), .DATA_W(36)) dut (.*);
    fabric_user_model partner (.*);

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task automatic tally_and_finish();
        if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input logic [35:0] seen, input logic [35:0] want);
        comparisons++;
        if (seen !== want) begin
            err_total++;
            $display("wrong value at %0t: seen %0h expected %0h",
                     $time, seen, want);
        end
    endtask

    function automatic logic [35:0] lanes(input logic [3:0] m);
        for (int k = 0; k < 4; k++) begin
            lanes[9*k +: 9] = {9{m[k]}};
        end
    endfunction

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        prd     = prdata;
        perr    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic port(input logic p, input logic w, input logic r,
                        input logic [7:0] a, input logic [3:0] m,
                        input logic [35:0] d);
        @(posedge pclk);
        if (p) begin
            we_b    <= w;
            re_b    <= r;
            addr_b  <= a;
            mask_b  <= m;
            wdata_b <= d;
        end else begin
            we_a    <= w;
            re_a    <= r;
            addr_a  <= a;
            mask_a  <= m;
            wdata_a <= d;
        end
        @(posedge pclk);
        {we_a, re_a, we_b, re_b} <= 4'h0;
        repeat (5) @(posedge pclk);
    endtask

    initial begin
        repeat (6000) @(posedge pclk);
        err_total++;
        tally_and_finish();
    end

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, clr_a, clr_b, share} = 6'h00;
        {we_a, re_a, we_b, re_b, mask_a, mask_b} = 12'h000;
        {paddr, pwdata, addr_a, addr_b} = 60'h0;
        {wdata_a, wdata_b, shift_in} = 108'h0;
        {run_a, run_b, ce_a, ce_b} = 4'hF;
        err_total = 0;
        comparisons = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFS_CONFIG, 32'h0);
        check(36'(prd), 36'(CFG_RESET));
        apb(1'b0, OFS_SHIFT, 32'h0);
        check(36'(prd), 36'(SH_RESET));
        apb(1'b0, 12'h00C, 32'h0);
        check(36'({perr, prd}), 36'h1_0000_0000);
        apb(1'b1, OFS_STATUS, 32'hFFFFFFFF);
        apb(1'b0, OFS_STATUS, 32'h0);
        check(36'({perr, prd[0]}), 36'h0);
        port(1'b0, 1'b1, 1'b0, 8'h10, 4'hF, 36'h0);
        exp = 36'h0;
        for (int m = 0; m < 16; m++) begin
            wd = 36'h9_8765_4321 ^ {9{m[3:0]}};
            port(1'b0, 1'b1, 1'b0, 8'h10, m[3:0], wd);
            exp = (exp & ~lanes(m[3:0])) | (wd & lanes(m[3:0]));
            port(m[0], 1'b0, 1'b1, 8'h10, 4'h0, 36'h0);
            check(m[0] ? rdata_b : rdata_a, exp);
        end
        port(1'b0, 1'b1, 1'b0, 8'h20, 4'hF, 36'h0);
        @(posedge pclk);
        run_a <= 1'b0;
        port(1'b0, 1'b1, 1'b0, 8'h20, 4'hF, 36'h1_2345_6789);
        @(posedge pclk);
        run_a <= 1'b1;
        ce_a  <= 1'b0;
        port(1'b0, 1'b1, 1'b0, 8'h20, 4'hF, 36'h1_2345_6789);
        @(posedge pclk);
        ce_a <= 1'b1;
        port(1'b0, 1'b0, 1'b1, 8'h20, 4'h0, 36'h0);
        check(rdata_a, 36'h0);
        port(1'b0, 1'b0, 1'b1, 8'h10, 4'h0, 36'h0);
        port(1'b1, 1'b0, 1'b1, 8'h10, 4'h0, 36'h0);
        @(posedge pclk);
        clr_a <= 1'b1;
        ce_a  <= 1'b0;
        @(posedge pclk);
        clr_a <= 1'b0;
        @(posedge pclk);
        check(rdata_a, 36'h0);
        check(rdata_b, exp);
        ce_a <= 1'b1;
        port(1'b0, 1'b1, 1'b0, 8'h30, 4'hF, 36'h0);
        apb(1'b1, OFS_CONFIG, 32'h0);
        port(1'b0, 1'b1, 1'b0, 8'h30, 4'h0, 36'hF_FFFF_FFFF);
        apb(1'b1, OFS_CONFIG, 32'h180);
        port(1'b0, 1'b1, 1'b0, 8'h30, 4'h2, 36'h0_0000_AB00);
        apb(1'b1, OFS_CONFIG, 32'h100);
        port(1'b0, 1'b1, 1'b0, 8'h30, 4'hC, 36'hF_FFFF_FFFF);
        apb(1'b1, OFS_CONFIG, 32'h200);
        port(1'b0, 1'b0, 1'b1, 8'h30, 4'h0, 36'h0);
        check(36'(rdata_a[35:18]), 36'h0);
        check(36'(rdata_a[8:0]), 36'h1FF);
        check(36'(rdata_a[16:9]), 36'hAB);
        @(posedge pclk);
        share <= 1'b1;
        apb(1'b1, OFS_CONFIG, 32'h262);
        port(1'b0, 1'b1, 1'b0, 8'h50, 4'hF, 36'h0_A5A5_A5A5);
        port(1'b1, 1'b1, 1'b0, 8'h50, 4'hF, 36'h0);
        port(1'b1, 1'b0, 1'b1, 8'h50, 4'h0, 36'h0);
        check(rdata_b, 36'h0_A5A5_A5A5);
        @(posedge pclk);
        {clr_a, clr_b} <= 2'b11;
        @(posedge pclk);
        {clr_a, clr_b} <= 2'b00;
        @(posedge pclk);
        check(rdata_b, 36'h0);
        share <= 1'b0;
        run_a <= 1'b0;
        apb(1'b1, OFS_CONFIG, 32'h219);
        port(1'b0, 1'b1, 1'b0, 8'h60, 4'hF, 36'h3_3C3C_3C3C);
        port(1'b0, 1'b0, 1'b1, 8'h60, 4'h0, 36'h0);
        check(rdata_a, 36'h3_3C3C_3C3C);
        ce_b <= 1'b0;
        port(1'b0, 1'b1, 1'b0, 8'h60, 4'hF, 36'h0_5A5A_5A5A);
        port(1'b0, 1'b0, 1'b1, 8'h60, 4'h0, 36'h0);
        check(rdata_a, 36'h3_3C3C_3C3C);
        apb(1'b1, OFS_CONFIG, 32'h239);
        repeat (2) @(posedge pclk);
        check(rdata_a, 36'h0_5A5A_5A5A);
        ce_b  <= 1'b1;
        run_a <= 1'b1;
        apb(1'b1, OFS_CONFIG, 32'h600);
        apb(1'b1, OFS_SHIFT, 32'h0000C881);
        apb(1'b0, OFS_STATUS, 32'h0);
        check(36'(prd[ST_ERR_BIT]), 36'h1);
        apb(1'b1, OFS_SHIFT, 32'h0000C880);
        apb(1'b0, OFS_STATUS, 32'h0);
        check(36'(prd[ST_ERR_BIT]), 36'h0);
        apb(1'b1, OFS_SHIFT, SH_RESET);
        for (int i = 1; i <= 40; i++) begin
            @(posedge pclk);
            shift_in <= 36'(i);
        end
        @(posedge pclk);
        {run_a, run_b} <= 2'b00;
        repeat (5) @(posedge pclk);
        check(shift_out, 36'h18);
        tally_and_finish();
    end
endmodule

bind dp_ram_core dp_ram_core_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W))
    chk (.*);
`default_nettype wire
